// ---- hw/bsm_pkg.sv ----
// Constants and types for the boot strap mode selector
`default_nettype none

package bsm_pkg;

    // Strap level patterns, strap a in bit 1, strap b in bit 0
    localparam logic [1:0] BSM_STRAP_FLASH  = 2'h3;
    localparam logic [1:0] BSM_STRAP_CAN    = 2'h2;
    localparam logic [1:0] BSM_STRAP_USB    = 2'h1;
    localparam logic [1:0] BSM_STRAP_SERIAL = 2'h0;

    // Most pins that start-up may reserve, straps included
    localparam int unsigned BSM_MAX_PINS = 4;

    // Pins every boot holds as straps, and link pins per serial path
    localparam int unsigned BSM_STRAP_PINS = 2;
    localparam int unsigned BSM_LINK_PINS  = 2;

    // Boot modes, one-hot
    typedef enum logic [3:0] {
        BSM_MODE_FLASH  = 4'h1,
        BSM_MODE_CAN    = 4'h2,
        BSM_MODE_USB    = 4'h4,
        BSM_MODE_SERIAL = 4'h8
    } bsm_mode_t;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        BSM_ST_SAMPLE = 4'h1,
        BSM_ST_DECIDE = 4'h2,
        BSM_ST_CLAIM  = 4'h4,
        BSM_ST_DONE   = 4'h8
    } bsm_state_t;

endpackage

`default_nettype wire

// ---- hw/bsm_boot_mode_select.sv ----
// Boot strap mode selector: samples straps once, picks a start-up path, claims link pins
`timescale 1ns/100ps
`default_nettype none

module bsm_boot_mode_select
    import bsm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       boot_strap_a,
    input  wire logic       boot_strap_b,
    input  wire logic       image_check_done,
    input  wire logic       image_valid,
    output var  logic       mode_valid,
    output var  logic       boot_from_flash,
    output var  logic       in_system_programming,
    output var  logic [3:0] boot_mode,
    output var  logic       claim_serial_port0,
    output var  logic       claim_can_port,
    output var  logic       claim_usb_bus_power_sense,
    output var  logic       straps_released
);

    typedef struct packed {
        bsm_state_t state;
        logic [1:0] straps;
        bsm_mode_t  mode;
        logic       mode_valid;
        logic [3:0] mode_out;
        logic       flash;
        logic       prog;
        logic       serial;
        logic       can;
        logic       usb;
        logic       released;
    } bsm_regs_t;

    bsm_regs_t r;
    bsm_regs_t next_r;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        case (r.state)
            BSM_ST_SAMPLE: begin
                next_r.straps = {boot_strap_a, boot_strap_b};
                next_r.state  = BSM_ST_DECIDE;
            end
            BSM_ST_DECIDE: begin
                case (r.straps)
                    BSM_STRAP_FLASH: begin
                        // Wait for the image check before choosing
                        if (image_check_done) begin
                            next_r.mode  = image_valid ? BSM_MODE_FLASH : BSM_MODE_USB;
                            next_r.state = BSM_ST_CLAIM;
                        end
                    end
                    BSM_STRAP_CAN: begin
                        next_r.mode  = BSM_MODE_CAN;
                        next_r.state = BSM_ST_CLAIM;
                    end
                    BSM_STRAP_USB: begin
                        next_r.mode  = BSM_MODE_USB;
                        next_r.state = BSM_ST_CLAIM;
                    end
                    default: begin
                        next_r.mode  = BSM_MODE_SERIAL;
                        next_r.state = BSM_ST_CLAIM;
                    end
                endcase
            end
            BSM_ST_CLAIM: begin
                // Mode is settled; claim only its own link pins
                next_r.mode_valid = 1'b1;
                next_r.flash      = (r.mode == BSM_MODE_FLASH);
                next_r.mode_out   = r.mode;
                next_r.prog       = (r.mode != BSM_MODE_FLASH);
                next_r.serial     = (r.mode == BSM_MODE_SERIAL);
                next_r.can        = (r.mode == BSM_MODE_CAN);
                next_r.usb        = (r.mode == BSM_MODE_USB);
                // Both straps flagged released in every mode, flash boot included
                next_r.released   = 1'b1;
                next_r.state      = BSM_ST_DONE;
            end
            BSM_ST_DONE: begin
                next_r.state = BSM_ST_DONE;
            end
            default: begin
                next_r.state = BSM_ST_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r.state      <= BSM_ST_SAMPLE;
            r.straps     <= 2'h0;
            r.mode       <= BSM_MODE_FLASH;
            r.mode_valid <= 1'b0;
            r.mode_out   <= '0;
            r.flash      <= 1'b0;
            r.prog       <= 1'b0;
            r.serial     <= 1'b0;
            r.can        <= 1'b0;
            r.usb        <= 1'b0;
            r.released   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a register
    // ------------------------------------------------------------
    assign mode_valid                = r.mode_valid;
    assign boot_from_flash           = r.flash;
    assign in_system_programming     = r.prog;
    assign boot_mode                 = r.mode_out;
    assign claim_serial_port0        = r.serial;
    assign claim_can_port            = r.can;
    assign claim_usb_bus_power_sense = r.usb;
    assign straps_released           = r.released;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] pin_count;
    // Straps always count; serial and CAN add link pins, USB reuses strap b
    assign pin_count = 3'(BSM_STRAP_PINS) + ((r.serial || r.can) ? 3'(BSM_LINK_PINS) : '0);

    pin_budget_a: assert property (@(posedge clk) disable iff (!reset_n)
        pin_count <= 3'(BSM_MAX_PINS)) else $error("too many boot pins");

    claim_after_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        (claim_serial_port0 || claim_can_port || claim_usb_bus_power_sense) |-> mode_valid)
        else $error("pins claimed before mode settled");

    one_claim_a: assert property (@(posedge clk) disable iff (!reset_n)
        $onehot0({claim_serial_port0, claim_can_port, claim_usb_bus_power_sense}))
        else $error("more than one link claimed");

    mode_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(mode_valid) && mode_valid |-> $stable(boot_mode))
        else $error("boot mode changed after latch");

    can_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(mode_valid) && r.straps == BSM_STRAP_CAN |-> claim_can_port)
        else $error("can strap not decoded");

    serial_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(mode_valid) && r.straps == BSM_STRAP_SERIAL |-> claim_serial_port0)
        else $error("serial strap not decoded");

    usb_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(mode_valid) && r.straps == BSM_STRAP_USB |-> claim_usb_bus_power_sense)
        else $error("usb strap not decoded");

    flash_fallback_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(mode_valid) && r.straps == BSM_STRAP_FLASH |->
            (boot_from_flash ^ claim_usb_bus_power_sense))
        else $error("flash boot decode wrong");

    prog_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode_valid |-> (boot_from_flash != in_system_programming))
        else $error("flash and programming flags disagree");

    strap_sample_a: assert property (@(posedge clk) disable iff (!reset_n)
        r.state == BSM_ST_SAMPLE |=> r.straps == {$past(boot_strap_a), $past(boot_strap_b)})
        else $error("straps not sampled at boot");

    decide_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        r.state == BSM_ST_DECIDE && r.straps != BSM_STRAP_FLASH |=> r.state == BSM_ST_CLAIM)
        else $error("strap decode stalled");

    flash_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
        r.state == BSM_ST_DECIDE && r.straps == BSM_STRAP_FLASH && !image_check_done
            |=> r.state == BSM_ST_DECIDE)
        else $error("flash boot chosen before image check");

    idle_outputs_a: assert property (@(posedge clk) disable iff (!reset_n)
        !mode_valid |-> boot_mode == '0 && !claim_serial_port0 && !claim_can_port)
        else $error("outputs active before mode settled");

    prog_claim_a: assert property (@(posedge clk) disable iff (!reset_n)
        in_system_programming |-> mode_valid)
        else $error("programming flagged before mode settled");

    release_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
        straps_released == mode_valid)
        else $error("straps released out of step with mode");

    flash_free_a: assert property (@(posedge clk) disable iff (!reset_n)
        boot_from_flash |-> !(claim_serial_port0 || claim_can_port || claim_usb_bus_power_sense))
        else $error("link pins claimed in flash boot");

    usb_sense_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode_valid && boot_mode == BSM_MODE_USB |-> claim_usb_bus_power_sense)
        else $error("usb mode without bus-power sense");

    strap_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        r.state == BSM_ST_DONE |-> $stable(r.straps))
        else $error("straps resampled after decision");

    claim_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(mode_valid) && mode_valid
            |-> $stable({claim_serial_port0, claim_can_port, claim_usb_bus_power_sense}))
        else $error("link claim changed after latch");

endmodule

`default_nettype wire

// ---- dv/bsm_host_model.sv ----
// Programming host and board strap drivers
`timescale 1ns/100ps
`default_nettype none
module bsm_host_model (
    input  wire logic       clk,
    input  wire logic [1:0] strap_sel,
    input  wire logic       usb_power,
    input  wire logic       straps_released,
    output var  logic       boot_strap_a,
    output var  logic       boot_strap_b
);
    // Straps toggle once released (strap b held high while usb_power), so a late resample shows
    always_ff @(negedge clk) begin
        if (!straps_released) begin
            {boot_strap_a, boot_strap_b} <= strap_sel;
        end else begin
            boot_strap_a <= ~boot_strap_a;
            boot_strap_b <= usb_power ? 1'b1 : ~boot_strap_b;
        end
    end
endmodule
`default_nettype wire

// ---- dv/bsm_boot_mode_select_tb.sv ----
// Self-checking bench for the boot strap mode selector
`timescale 1ns/100ps
`default_nettype none
module bsm_boot_mode_select_tb;
    import bsm_pkg::*;
    logic clk = 0, reset_n = 0, done = 0, valid = 0, usb = 0, a, b, mv, fl, prog, cs, cc, cu, rel;
    logic [1:0] sel = 2'h0;
    logic [3:0] mode;
    int failures = 0, checks = 0, cycles = 0;
    initial forever #2.5 clk = ~clk;
    bsm_host_model u_bsm_host_model (.clk(clk), .strap_sel(sel), .usb_power(usb),
        .straps_released(rel), .boot_strap_a(a), .boot_strap_b(b));
    bsm_boot_mode_select u_bsm_boot_mode_select (.clk(clk), .reset_n(reset_n),
        .boot_strap_a(a), .boot_strap_b(b), .image_check_done(done), .image_valid(valid),
        .mode_valid(mv), .boot_from_flash(fl), .in_system_programming(prog),
        .boot_mode(mode), .claim_serial_port0(cs), .claim_can_port(cc),
        .claim_usb_bus_power_sense(cu), .straps_released(rel));
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            $display("MISMATCH t=%0t timeout", $time);
            conclude();
        end
    end
    // One boot: reset, strap pattern, optional image check, then judge
    task automatic do_boot(input logic [1:0] s, input logic iv, input logic [3:0] exp);
        reset_n = 0;
        sel = s;
        valid = iv;
        done = 0;
        usb = (exp === BSM_MODE_USB);
        repeat (5) @(negedge clk);
        reset_n = 1;
        repeat (2) @(negedge clk);
        check(mv === 1'b0 && mode === 4'h0, "mode early");
        @(negedge clk);
        if (s === BSM_STRAP_FLASH) begin
            check(mv === 1'b0, "flash decided before check");
            repeat (4) @(negedge clk);
            done = 1;
            @(negedge clk);
            check(mv === 1'b0, "flash decided too soon");
            @(negedge clk);
        end
        check(mv === 1'b1 && rel === 1'b1, "mode not ready");
        repeat (10) @(negedge clk);
        check(mode === exp, "wrong mode");
        check(fl === (exp === BSM_MODE_FLASH) && prog === ~fl, "flash/programming flags");
        check(cs === (exp === BSM_MODE_SERIAL), "serial claim");
        check(cc === (exp === BSM_MODE_CAN), "can claim");
        check(cu === (exp === BSM_MODE_USB), "usb claim");
        check(4'(cs) + 4'(cc) + 4'(cu) <= 4'h1, "extra pins claimed");
        check(mv === 1'b1, "mode dropped");
    endtask
    task automatic test_links();
        do_boot(BSM_STRAP_CAN, 1'b0, BSM_MODE_CAN);
        do_boot(BSM_STRAP_USB, 1'b0, BSM_MODE_USB);
        do_boot(BSM_STRAP_SERIAL, 1'b1, BSM_MODE_SERIAL);
        $display("test_links done");
    endtask
    task automatic test_flash_ok();
        do_boot(BSM_STRAP_FLASH, 1'b1, BSM_MODE_FLASH);
        $display("test_flash_ok done");
    endtask
    task automatic test_flash_bad();
        do_boot(BSM_STRAP_FLASH, 1'b0, BSM_MODE_USB);
        $display("test_flash_bad done");
    endtask
    initial begin
        test_links();
        test_flash_ok();
        test_flash_bad();
        conclude();
    end
endmodule
`default_nettype wire
